// ===== verilog/rst_ctrl_pkg.sv
// package: constants, states and carriers for the reset controller
package rst_ctrl_pkg;
	localparam int PORT_COUNT = 8;
	localparam logic [7:0] RECOVERY_INDEX = 8'h05;
	localparam logic [7:0] RECOVERY_ENABLE_RESET = 8'h00;
	localparam int SYSTEM_OSC_CYCLES = 514;
	localparam int SHORT_OSC_CYCLES = 66;
	localparam int RECOVERY_OSC_CYCLES = 514;
	localparam int SYSCLK_CYCLES = 16;
	localparam int DEBUG_RESET_BIT = 1;
	localparam int OSC_COUNT_WIDTH = 10;
	localparam int SYS_COUNT_WIDTH = 5;

	typedef enum logic [1:0] {
		KIND_SYSTEM = 2'h0,
		KIND_SHORT = 2'h1,
		KIND_RECOVERY = 2'h2
	} reset_kind_t;

	// one-bit steps run -> osc -> sys; sys -> run changes both bits
	typedef enum logic [1:0] {
		SEQ_RUN = 2'h0,
		SEQ_OSC = 2'h1,
		SEQ_SYS = 2'h3
	} seq_state_t;

	// requests from the direct sources, plus the stop mode flag; debugger bit and port pins arrive separately
	typedef struct packed {
		logic powerOn;
		logic brownout;
		logic watchdogTimeout;
		logic externalResetN;
		logic debugPinN;
		logic stopMode;
	} reset_sources_t;

	// per-port register access strobes
	typedef struct packed {
		logic addrWrite;
		logic ctrlWrite;
		logic [7:0] data;
	} port_access_t;
endpackage

// ===== verilog/osc_edge_detect.sv
// watchdog oscillator edge detector on the system clock
module osc_edge_detect
	import rst_ctrl_pkg::*;
(
	input wire logic clock,
	input wire logic sysRst,
	input wire logic oscIn,
	output logic oscRise
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic last;
		logic rise;
		logic [1:0] fill;
	} edge_state_t;
	edge_state_t s_reg, s_next;

	// first stage feeds only the second stage
	always_comb begin
		s_next = s_reg;
		s_next.sync1 = oscIn;
		s_next.sync2 = s_reg.sync1;
		s_next.last = s_reg.sync2;
		// no edge until the chain has filled: an oscillator already
		// high as reset ends would otherwise count as a false rise
		s_next.fill = (s_reg.fill == 2'h3) ? 2'h3 : s_reg.fill + 2'h1;
		s_next.rise = (s_reg.fill == 2'h3) & s_reg.sync2 & ~s_reg.last;
	end

	always_ff @(posedge clock) begin
		if (sysRst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign oscRise = s_reg.rise;
endmodule

// ===== verilog/port_recovery_reg.sv
// one port's address register and recovery-enable sub-register
module port_recovery_reg
	import rst_ctrl_pkg::*;
(
	input wire logic clock,
	input wire logic sysRst,
	input wire logic regReset,
	input wire rst_ctrl_pkg::port_access_t access,
	input wire logic [7:0] pinIn,
	input wire logic stopMode,
	output logic [7:0] enableOut,
	output logic transition
);
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] enable;
		logic [7:0] lastPins;
		logic hit;
		logic primed;
	} port_state_t;
	port_state_t s_reg, s_next;

	always_comb begin
		s_next = s_reg;
		s_next.lastPins = pinIn;
		s_next.primed = 1'b1; // lastPins holds no real level before this
		if (access.addrWrite)
			s_next.addr = access.data;
		// sub-register only reachable via index in address reg
		if (access.ctrlWrite && s_reg.addr == RECOVERY_INDEX)
			s_next.enable = access.data;
		// enabled pins' transitions in stop mode; others ignored
		s_next.hit = s_reg.primed & stopMode &
			(|((pinIn ^ s_reg.lastPins) & s_reg.enable));
		if (regReset) begin
			s_next.addr = 8'h00;
			s_next.enable = RECOVERY_ENABLE_RESET;
		end
	end

	always_ff @(posedge clock) begin
		if (sysRst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign enableOut = s_reg.enable;
	assign transition = s_reg.hit;
endmodule

// ===== verilog/reset_stop_recovery_ctrl.sv
// reset and stop mode recovery controller
// Functional notes
// - reset on POR, brown-out, watchdog; pin and debugger only outside stop mode
// - debugger control bit 1 requests reset
// - watchdog resets only if option selects it
// - stop recovery on watchdog, port edge, debug low
// - kind chosen from mode and source
// - system reset: 514 osc plus 16 clocks
// - short reset: 66 osc plus 16 clocks
// - recovery keeps registers except watchdog control
// - enabled pin transitions in stop start recovery
// - enable sub-register at index 05H, resets zero
module reset_stop_recovery_ctrl
	import rst_ctrl_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic watchdogOsc,
	input wire rst_ctrl_pkg::reset_sources_t sources,
	input wire logic watchdogResetSelectOption,
	input wire logic [7:0] debuggerControlReg,
	input wire rst_ctrl_pkg::port_access_t [PORT_COUNT-1:0] portAccess,
	input wire logic [PORT_COUNT-1:0][7:0] portPins,
	output logic coreReset,
	output logic ctrlRegReset,
	output logic watchdogCtlReset,
	output rst_ctrl_pkg::reset_kind_t lastKind,
	output logic [PORT_COUNT-1:0][7:0] pinRecoveryEnable
);
	typedef struct packed {
		seq_state_t state;
		reset_kind_t kind;
		logic [OSC_COUNT_WIDTH-1:0] oscCount;
		logic [SYS_COUNT_WIDTH-1:0] sysCount;
		logic coreReset;
		logic ctrlReset;
		logic wdtReset;
		// output stage lives in the same state word
		logic outCore;
		logic outCtrl;
		logic outWdt;
		reset_kind_t outKind;
		logic [PORT_COUNT-1:0][7:0] outEnable;
	} ctrl_state_t;
	ctrl_state_t s_reg, s_next;

	logic oscRise;
	logic [PORT_COUNT-1:0] portHit;
	logic [PORT_COUNT-1:0][7:0] enables;
	logic fullReq, recoveryReq, shortReq;
	logic [OSC_COUNT_WIDTH-1:0] oscTarget;

	osc_edge_detect oscDetect (
		.clock(clock),
		.sysRst(sys_rst),
		.oscIn(watchdogOsc),
		.oscRise(oscRise)
	);

	// one register block per port
	generate
		for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
			port_recovery_reg portReg (
				.clock(clock),
				.sysRst(sys_rst),
				.regReset(s_reg.ctrlReset),
				.access(portAccess[p]),
				.pinIn(portPins[p]),
				.stopMode(sources.stopMode),
				.enableOut(enables[p]),
				.transition(portHit[p])
			);
		end
	endgenerate

	// request sorting; stop mode routes wakeups to recovery
	always_comb begin
		fullReq = sources.powerOn | sources.brownout;
		shortReq = ~sources.stopMode & (
			~sources.externalResetN |
			debuggerControlReg[DEBUG_RESET_BIT] |
			(sources.watchdogTimeout & watchdogResetSelectOption));
		recoveryReq = sources.stopMode & (sources.watchdogTimeout |
			(|portHit) | ~sources.debugPinN);
	end

	// osc target depends on kind: short is the quick one
	always_comb begin
		unique case (s_reg.kind)
			KIND_SHORT: oscTarget = OSC_COUNT_WIDTH'(SHORT_OSC_CYCLES);
			KIND_RECOVERY: oscTarget =
				OSC_COUNT_WIDTH'(RECOVERY_OSC_CYCLES);
			default: oscTarget = OSC_COUNT_WIDTH'(SYSTEM_OSC_CYCLES);
		endcase
	end

	// sequencer: power-on and brown-out restart at any time
	always_comb begin
		s_next = s_reg;
		unique case (s_reg.state)
			SEQ_RUN: begin
				if (fullReq || shortReq || recoveryReq) begin
					s_next.state = SEQ_OSC;
					s_next.oscCount = '0;
					s_next.sysCount = '0;
					s_next.coreReset = 1'b1;
					// kind picked from mode and source
					if (fullReq)
						s_next.kind = KIND_SYSTEM;
					else if (recoveryReq)
						s_next.kind = KIND_RECOVERY;
					else
						s_next.kind = KIND_SHORT;
					// recovery touches only watchdog control
					s_next.ctrlReset = ~recoveryReq | fullReq;
					s_next.wdtReset = 1'b1;
				end
			end
			SEQ_OSC: begin
				s_next.ctrlReset = 1'b0;
				s_next.wdtReset = 1'b0;
				if (oscRise)
					s_next.oscCount = s_reg.oscCount + 1'b1;
				if (oscRise && s_reg.oscCount == oscTarget - 1'b1)
					s_next.state = SEQ_SYS;
			end
			SEQ_SYS: begin
				s_next.sysCount = s_reg.sysCount + 1'b1;
				// release only after the clock count ends
				if (s_reg.sysCount == SYS_COUNT_WIDTH'(SYSCLK_CYCLES - 1)) begin
					s_next.state = SEQ_RUN;
					s_next.coreReset = 1'b0;
				end
			end
			// unused code: fall back to a system-kind sequence, without the register reset pulses
			default: begin
				s_next.state = SEQ_OSC;
				s_next.kind = KIND_SYSTEM;
				s_next.oscCount = '0;
				s_next.sysCount = '0;
				s_next.coreReset = 1'b1;
			end
		endcase
		if (fullReq && s_reg.state != SEQ_RUN) begin
			s_next.state = SEQ_OSC;
			s_next.kind = KIND_SYSTEM;
			s_next.oscCount = '0;
			s_next.sysCount = '0;
			s_next.coreReset = 1'b1;
			s_next.ctrlReset = 1'b1;
			s_next.wdtReset = 1'b1;
		end
		// output stage one clock behind the sequencer, glitch free
		s_next.outCore = s_reg.coreReset;
		s_next.outCtrl = s_reg.ctrlReset;
		s_next.outWdt = s_reg.wdtReset;
		s_next.outKind = s_reg.kind;
		s_next.outEnable = enables;
	end

	// reset state holds the core in reset as a system reset
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_reg.state <= SEQ_OSC;
			s_reg.kind <= KIND_SYSTEM;
			s_reg.oscCount <= '0;
			s_reg.sysCount <= '0;
			s_reg.coreReset <= 1'b1;
			s_reg.ctrlReset <= 1'b1;
			s_reg.wdtReset <= 1'b1;
			s_reg.outCore <= 1'b1;
			s_reg.outCtrl <= 1'b1;
			s_reg.outWdt <= 1'b1;
			s_reg.outKind <= KIND_SYSTEM;
			s_reg.outEnable <= '0;
		end else
			s_reg <= s_next;
	end

	// outputs come straight from the output stage flops
	assign coreReset = s_reg.outCore;
	assign ctrlRegReset = s_reg.outCtrl;
	assign watchdogCtlReset = s_reg.outWdt;
	assign lastKind = s_reg.outKind;
	assign pinRecoveryEnable = s_reg.outEnable;
endmodule

// ===== verif/wdt_osc_model.sv
// stand-in for the free-running watchdog oscillator
module wdt_osc_model (
	output logic watchdogOsc
);
	timeunit 1ns;
	timeprecision 1ns;
	// 80 ns period, under a third of the clock, phase unrelated
	initial begin
		watchdogOsc = 1'b0;
		#7;
		forever #40 watchdogOsc = ~watchdogOsc;
	end
endmodule

// ===== verif/rst_ctrl_properties.sv
// port assertions for the reset controller
module rst_ctrl_properties
	import rst_ctrl_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire rst_ctrl_pkg::reset_sources_t sources,
	input wire logic watchdogResetSelectOption,
	input wire logic [7:0] debuggerControlReg,
	input wire logic [PORT_COUNT-1:0][7:0] portPins,
	input wire logic coreReset,
	input wire logic ctrlRegReset,
	input wire logic watchdogCtlReset,
	input wire rst_ctrl_pkg::reset_kind_t lastKind,
	input wire logic [PORT_COUNT-1:0][7:0] pinRecoveryEnable
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// idle in normal mode and in stop mode
	wire run = !coreReset && !sources.stopMode;
	wire stop = !coreReset && sources.stopMode;
	property p_pin;
		run && !sources.externalResetN |-> ##2 coreReset;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset missed");
	property p_dbg;
		run && debuggerControlReg[DEBUG_RESET_BIT] |-> ##2 coreReset;
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug reset missed");
	property p_wdt;
		run && sources.watchdogTimeout && watchdogResetSelectOption
			|-> ##2 coreReset;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset missed");
	property p_kind;
		$rose(coreReset) && lastKind == KIND_RECOVERY
			|-> !ctrlRegReset && watchdogCtlReset;
	endproperty
	a_kind: assert property (p_kind) else $error("recovery scope wrong");
	property p_tail;
		$fell(coreReset) |-> $past(coreReset, 16);
	endproperty
	a_tail: assert property (p_tail) else $error("clock tail short");
	property p_wake;
		stop && |((portPins ^ $past(portPins)) & pinRecoveryEnable)
			|-> ##[1:4] coreReset;
	endproperty
	a_wake: assert property (p_wake) else $error("pin wake missed");
	property p_dwake;
		stop && !sources.debugPinN |-> ##[1:3] coreReset;
	endproperty
	a_dwake: assert property (p_dwake) else $error("debug wake missed");
	property p_clear;
		ctrlRegReset |-> ##[1:2] pinRecoveryEnable == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("enables kept");
	// an osc cycle spans at least three clocks, so these are floors
	localparam int SHORT_FLOOR = SHORT_OSC_CYCLES * 3 + SYSCLK_CYCLES;
	localparam int SYSTEM_FLOOR = SYSTEM_OSC_CYCLES * 3 + SYSCLK_CYCLES;
	localparam int RECOVERY_FLOOR = RECOVERY_OSC_CYCLES * 3 + SYSCLK_CYCLES;
	logic [11:0] holdCount;
	// clocks spent in core reset, saturating
	always_ff @(posedge clock) begin
		if (sys_rst || !coreReset)
			holdCount <= 12'h000;
		else if (holdCount != 12'hfff)
			holdCount <= holdCount + 12'h001;
	end
	property p_hold;
		$fell(coreReset) |-> holdCount >= ((lastKind == KIND_SHORT) ?
			SHORT_FLOOR : ((lastKind == KIND_RECOVERY) ?
			RECOVERY_FLOOR : SYSTEM_FLOOR));
	endproperty
	a_hold: assert property (p_hold) else $error("hold too short");
endmodule
bind reset_stop_recovery_ctrl rst_ctrl_properties i_props(.clock, .sys_rst,
	.sources, .watchdogResetSelectOption, .debuggerControlReg, .portPins,
	.coreReset, .ctrlRegReset, .watchdogCtlReset, .lastKind,
	.pinRecoveryEnable);

// ===== verif/tb_reset_stop_recovery_ctrl.sv
// self-checking bench for the reset controller
module tb_reset_stop_recovery_ctrl
	import rst_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic opt = 1'b0;
	logic watchdogOsc, coreReset, ctrlRegReset, watchdogCtlReset;
	reset_kind_t lastKind;
	reset_sources_t src = 6'b000110;
	logic [7:0] dbg = 8'h00;
	port_access_t [PORT_COUNT-1:0] acc = '0;
	logic [PORT_COUNT-1:0][7:0] pins = '0;
	logic [PORT_COUNT-1:0][7:0] en;
	int num_errors = 0;
	int cmp_count = 0;
	initial forever #10 clock = ~clock;
	wdt_osc_model i_osc(.watchdogOsc(watchdogOsc));
	reset_stop_recovery_ctrl i_dut(.clock, .sys_rst, .watchdogOsc,
		.sources(src), .watchdogResetSelectOption(opt),
		.debuggerControlReg(dbg), .portAccess(acc), .portPins(pins),
		.coreReset, .ctrlRegReset, .watchdogCtlReset, .lastKind,
		.pinRecoveryEnable(en));
	task automatic complete_run;
		$display("compares %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [63:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic bail;
		num_errors++;
		complete_run();
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	// one-cycle pulse of a request, then sources back to idle; a pin toggle stays in place
	task automatic fire(input int s);
		case (s)
			0: src.brownout = 1'b1;
			1: src.externalResetN = 1'b0;
			2: dbg[DEBUG_RESET_BIT] = 1'b1;
			3: src.watchdogTimeout = 1'b1;
			4: src.debugPinN = 1'b0;
			13: src.powerOn = 1'b1;
			default: pins[0][s-5] = ~pins[0][s-5];
		endcase
		tick(1);
		src = {5'b00011, src.stopMode};
		dbg = 8'h00;
	endtask
	// osc phase is free, so the hold length gets a few cycles of slack
	task automatic seq(input reset_kind_t k, input int n);
		int c;
		c = 0;
		while (coreReset !== 1'b1 && c < 4) begin
			tick(1);
			c++;
		end
		if (c == 4) bail();
		check(lastKind, k);
		check(ctrlRegReset, k != KIND_RECOVERY);
		check(watchdogCtlReset, 1'b1);
		c = 0;
		while (coreReset !== 1'b0 && c < 3000) begin
			tick(1);
			c++;
		end
		if (c == 3000) bail();
		check(c >= n * 4 + 12 && c <= n * 4 + 24, 1'b1);
		check({ctrlRegReset, watchdogCtlReset}, 2'b00);
		$display("sequence of kind %0d done in %0d", k, c);
	endtask
	// address write then control write, result two edges later
	task automatic wr(input int p, input logic [7:0] a, d);
		acc[p] = {2'b10, a};
		tick(1);
		acc[p] = {2'b01, d};
		tick(1);
		acc[p] = '0;
		tick(2);
	endtask
	initial begin
		logic [7:0] d;
		void'($urandom(6206));
		tick(3);
		sys_rst = 1'b0;
		seq(KIND_SYSTEM, SYSTEM_OSC_CYCLES);
		check(en, '0);
		fire(0);
		seq(KIND_SYSTEM, SYSTEM_OSC_CYCLES);
		fire(1);
		seq(KIND_SHORT, SHORT_OSC_CYCLES);
		fire(2);
		seq(KIND_SHORT, SHORT_OSC_CYCLES);
		fire(3);
		tick(8);
		check(coreReset, 1'b0);
		opt = 1'b1;
		fire(3);
		seq(KIND_SHORT, SHORT_OSC_CYCLES);
		for (int p = 0; p < PORT_COUNT; p++) begin
			d = (p == 0) ? 8'h01 : 8'($urandom);
			wr(p, RECOVERY_INDEX, d);
			check(en[p], d);
			wr(p, 8'($urandom) | 8'h08, ~d);
			check(en[p], d);
		end
		$display("register test done");
		src.stopMode = 1'b1;
		tick(1);
		fire(6);
		tick(8);
		check(coreReset, 1'b0);
		fire(5);
		seq(KIND_RECOVERY, RECOVERY_OSC_CYCLES);
		check(en[0], 8'h01);
		fire(4);
		seq(KIND_RECOVERY, RECOVERY_OSC_CYCLES);
		opt = 1'b0;
		fire(3);
		seq(KIND_RECOVERY, RECOVERY_OSC_CYCLES);
		src.stopMode = 1'b0;
		tick(1);
		fire(1);
		tick(20);
		fire(13);
		tick(1);
		seq(KIND_SYSTEM, SYSTEM_OSC_CYCLES);
		check(en, '0);
		sys_rst = 1'b1;
		tick(3);
		sys_rst = 1'b0;
		seq(KIND_SYSTEM, SYSTEM_OSC_CYCLES);
		complete_run();
	end
endmodule
